// *** watchdog_defs.svh ***
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define WATCHDOG_CTRL_INDEX       30'h0000_0012
`define WATCHDOG_CSR_INDEX        30'h0000_0013

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define WATCHDOG_RA_BIT           7
`define WATCHDOG_TOP_BIT          6
`define WATCHDOG_FLAG_BIT         1
`define WATCHDOG_IE_BIT           0

// -----------------------------------------------------------------------------
// reset values and count constants
// -----------------------------------------------------------------------------
`define WATCHDOG_CTRL_RESET       8'h7f
`define WATCHDOG_CSR_RESET        8'h00
`define WATCHDOG_COUNT_ROLL       7'h40
`define WATCHDOG_TICK_CYCLES      32'h0001_0000

`endif

// *** watchdog_pkg.sv ***
// types shared by the watchdog design
package watchdog_pkg;

	// what the watchdog does in a given cycle
	typedef enum logic [1:0] {
		EV_NONE,
		EV_RESET,
		EV_IRQ
	} watchdog_event_t;

endpackage : watchdog_pkg

// *** watchdog_prescaler.sv ***
// divider that turns the cpu clock into a one-cycle count step pulse
`timescale 1ns/10ps
`default_nettype none

module watchdog_prescaler #(
	parameter int unsigned DIVISOR = 65536
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// control
	input  wire logic run,
	// step pulse
	output var  logic tick
);

	localparam int unsigned CNT_W = (DIVISOR > 1) ? $clog2(DIVISOR) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DIVISOR - 1);

	generate
		if (DIVISOR < 2) begin : g_bad_divisor
			$error("watchdog_prescaler: DIVISOR must be at least 2");
		end
	endgenerate

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_tick;

	// the divider holds still while frozen, so halt resumes the interval
	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'b0;
		if (run) begin
			if (cnt == LAST) begin
				next_cnt  = '0;
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end

endmodule : watchdog_prescaler

`default_nettype wire

// *** watchdog_timer.sv ***
// watchdog timer with ahb-lite register slave, reset and top-level interrupt
//
// Notes on behaviour
// - count steps down every 65536 cycles
// - event when count rolls 40h to 3Fh
// - count runs unless halted; control writes reload
// - disabled after reset; only reset disables
// - activation with top bit clear resets
// - no options: activation reset, enable interrupt, else nothing
// - interrupt option: activation reset, else interrupt
// - reset option always resets, has priority
// - wait runs, halt freezes the count
// - activation bit set-only, timeout then resets
// - activation bit ignored under reset option
// - flag sets on interrupt timeout, status read clears
// - flag unused when configured for reset
// - enable set-only, requests interrupt, reset dominates
// - interrupt option forces enable to one
// - control resets to 7Fh
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"

module watchdog_timer
	import watchdog_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `WATCHDOG_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	// option byte and power mode
	input  wire logic        hardware_reset_option,
	input  wire logic        hardware_interrupt_option,
	input  wire logic        halt_mode,
	// requests to reset and interrupt logic
	output var  logic        wdg_reset_req,
	output var  logic        top_level_interrupt
);

	// -------------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------------
	function automatic logic hits(input logic [31:0] addr, input logic [29:0] idx);
		hits = (addr[31:2] == idx);
	endfunction : hits

	// -------------------------------------------------------------------------
	// parameter check
	// -------------------------------------------------------------------------
	generate
		if (TICK_CYCLES < 2) begin : g_bad_tick
			$error("watchdog_timer: TICK_CYCLES must be at least 2");
		end
	endgenerate

	// -------------------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------------------
	// taken apart by field so every reset assignment keeps its own width
	localparam logic [7:0] CTRL_RESET = `WATCHDOG_CTRL_RESET;
	localparam logic [7:0] CSR_RESET  = `WATCHDOG_CSR_RESET;

	// -------------------------------------------------------------------------
	// step pulse
	// -------------------------------------------------------------------------
	logic tick;
	logic step;

	watchdog_prescaler #(
		.DIVISOR (TICK_CYCLES)
	) u_prescaler (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.run     (!halt_mode),
		.tick    (tick)
	);

	assign step = tick && !halt_mode;

	// -------------------------------------------------------------------------
	// bus phases
	// -------------------------------------------------------------------------
	logic        dph_wr_ctrl;
	logic        dph_wr_csr;
	logic        next_dph_wr_ctrl;
	logic        next_dph_wr_csr;
	logic [31:0] next_hrdata;
	logic        addr_ok;
	logic        read_csr;
	logic        wr_ctrl;
	logic        wr_csr;

	// -------------------------------------------------------------------------
	// watchdog state
	// -------------------------------------------------------------------------
	logic            reset_activation;
	logic [6:0]      count;
	logic            interrupt_enable_bit;
	logic            timeout_flag;
	logic            next_reset_activation;
	logic [6:0]      next_count;
	logic            next_interrupt_enable_bit;
	logic            next_timeout_flag;
	logic            enable_eff;
	logic            reset_mode;
	logic            roll;
	watchdog_event_t ev;

	assign addr_ok  = hsel && htrans[1] && hready;
	assign read_csr = addr_ok && !hwrite && hits(haddr, `WATCHDOG_CSR_INDEX);
	assign wr_ctrl  = dph_wr_ctrl;
	assign wr_csr   = dph_wr_csr;

	assign enable_eff = interrupt_enable_bit || hardware_interrupt_option;
	assign reset_mode = reset_activation || hardware_reset_option;

	// zero wait states: read data is captured in the address phase
	always_comb begin
		next_dph_wr_ctrl = addr_ok && hwrite && hits(haddr, `WATCHDOG_CTRL_INDEX);
		next_dph_wr_csr  = addr_ok && hwrite && hits(haddr, `WATCHDOG_CSR_INDEX);
		next_hrdata      = hrdata;
		if (addr_ok && !hwrite) begin
			next_hrdata = 32'h0000_0000;
			if (hits(haddr, `WATCHDOG_CTRL_INDEX)) begin
				next_hrdata[7:0] = {reset_activation, count};
			end else if (hits(haddr, `WATCHDOG_CSR_INDEX)) begin
				next_hrdata[`WATCHDOG_FLAG_BIT] = timeout_flag;
				next_hrdata[`WATCHDOG_IE_BIT]   = enable_eff;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dph_wr_ctrl <= 1'b0;
			dph_wr_csr  <= 1'b0;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			dph_wr_ctrl <= next_dph_wr_ctrl;
			dph_wr_csr  <= next_dph_wr_csr;
			hrdata      <= next_hrdata;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// counter, flags and events
	// -------------------------------------------------------------------------
	// rollover detection
	assign roll = step && (count == `WATCHDOG_COUNT_ROLL) && !wr_ctrl;

	always_comb begin
		next_reset_activation     = reset_activation;
		next_interrupt_enable_bit = interrupt_enable_bit;
		next_count                = count;
		ev                        = EV_NONE;
		if (wr_ctrl) begin
			next_count = hwdata[6:0];
		end else if (step) begin
			next_count = count - 7'h01;
		end
		if (wr_ctrl && hwdata[`WATCHDOG_RA_BIT]) begin
			next_reset_activation = 1'b1;
		end
		if (wr_csr && hwdata[`WATCHDOG_IE_BIT]) begin
			next_interrupt_enable_bit = 1'b1;
		end
		if (wr_ctrl && hwdata[`WATCHDOG_RA_BIT] && !hwdata[`WATCHDOG_TOP_BIT]) begin
			ev = EV_RESET;
		end else if (roll && reset_mode) begin
			ev = EV_RESET;
		end else if (roll && enable_eff) begin
			ev = EV_IRQ;
		end
		next_timeout_flag = (ev == EV_IRQ) || (timeout_flag && !read_csr);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reset_activation     <= CTRL_RESET[`WATCHDOG_RA_BIT];
			count                <= CTRL_RESET[`WATCHDOG_TOP_BIT:0];
			interrupt_enable_bit <= CSR_RESET[`WATCHDOG_IE_BIT];
			timeout_flag         <= CSR_RESET[`WATCHDOG_FLAG_BIT];
			wdg_reset_req        <= 1'b0;
			top_level_interrupt  <= 1'b0;
		end else begin
			reset_activation     <= next_reset_activation;
			count                <= next_count;
			interrupt_enable_bit <= next_interrupt_enable_bit;
			timeout_flag         <= next_timeout_flag;
			wdg_reset_req        <= (ev == EV_RESET);
			top_level_interrupt  <= (ev == EV_IRQ);
		end
	end

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_count_step: assert property (step && !wr_ctrl |=> count == $past(count) - 7'h01)
		else $error("count did not step down on tick");

	a_write_reload: assert property (wr_ctrl |=> count == $past(hwdata[6:0]))
		else $error("control write did not reload count");

	a_roll_reset: assert property (
		roll && reset_mode |=> wdg_reset_req && !top_level_interrupt)
		else $error("rollover in reset mode gave no reset");

	a_roll_irq: assert property (
		roll && !reset_mode && enable_eff |=> top_level_interrupt && timeout_flag)
		else $error("rollover in interrupt mode gave no interrupt");

	a_hw_reset: assert property (roll && hardware_reset_option |=> wdg_reset_req)
		else $error("hardware reset option did not force reset");

	a_soft_reset: assert property (wr_ctrl && hwdata[7] && !hwdata[6] |=> wdg_reset_req)
		else $error("software reset write ignored");

	a_activation_held: assert property (reset_activation |=> reset_activation)
		else $error("activation bit cleared without reset");

	a_enable_held: assert property (interrupt_enable_bit |=> interrupt_enable_bit)
		else $error("interrupt enable cleared without reset");

	a_halt_freeze: assert property (halt_mode && !wr_ctrl |=> $stable(count))
		else $error("count moved during halt");

	a_flag_clear: assert property (read_csr && ev != EV_IRQ |=> !timeout_flag)
		else $error("status read did not clear flag");

	a_flag_unused: assert property (reset_mode |=> !$rose(timeout_flag))
		else $error("flag set in reset mode");

	a_forced_enable: assert property (hardware_interrupt_option && read_csr |=> hrdata[0])
		else $error("forced enable did not read as one");

	a_ctrl_reset: assert property ($fell(sys_rst) |-> count == 7'h7f && !reset_activation)
		else $error("control reset value wrong");

	a_irq_pulse: assert property (top_level_interrupt |=> !top_level_interrupt)
		else $error("interrupt request longer than one cycle");

	a_reset_pulse: assert property (wdg_reset_req |=> !wdg_reset_req)
		else $error("reset request longer than one cycle");

	a_quiet_unarmed: assert property (
		roll && !reset_mode && !enable_eff |=> !wdg_reset_req && !top_level_interrupt)
		else $error("rollover while disarmed raised a request");

	a_no_irq_reset: assert property (reset_mode |=> !top_level_interrupt)
		else $error("interrupt raised in reset mode");

	a_irq_sets_flag: assert property (top_level_interrupt |-> timeout_flag)
		else $error("interrupt without timeout flag");

	a_flag_held: assert property (timeout_flag && !read_csr |=> timeout_flag)
		else $error("timeout flag lost without status read");

	a_write_quiet: assert property (
		wr_ctrl && !(hwdata[7] && !hwdata[6]) |=> !wdg_reset_req && !top_level_interrupt)
		else $error("control write raised a request");

	c_reset_timeout: cover property (roll && reset_activation ##1 wdg_reset_req);
	c_irq_timeout: cover property (roll && !reset_mode ##1 top_level_interrupt ##[1:20] read_csr);
	c_soft_reset: cover property (wr_ctrl && hwdata[7] && !hwdata[6]);
	c_halt_freeze: cover property (halt_mode && wr_ctrl);

endmodule : watchdog_timer

`default_nettype wire

// *** wdg_host_model.sv ***
// model of the cpu reset logic and the top-level interrupt controller
`timescale 1ns/10ps
`default_nettype none

module wdg_host_model (
	// clock
	input  wire logic ref_clk,
	// requests from the watchdog
	input  wire logic wdg_reset_req,
	input  wire logic top_level_interrupt,
	// reset back to the device and event counts
	output var  logic cpu_rst,
	output var  int   rst_cnt,
	output var  int   irq_cnt
);
	int hold;

	initial begin
		hold = 0;
		rst_cnt = 0;
		irq_cnt = 0;
	end

	// one count per high cycle, so a stretched request shows up as extra events
	always @(posedge ref_clk) begin
		if (wdg_reset_req === 1'b1) begin
			rst_cnt <= rst_cnt + 1;
			hold <= 4;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
		if (top_level_interrupt === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
		end
	end

	// reset stretcher: the device sits in reset for four cycles
	always_comb cpu_rst = (hold != 0);
endmodule : wdg_host_model
`default_nettype wire

// *** tb_watchdog_timer.sv ***
// self-checking testbench of the watchdog timer over ahb-lite
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("FAIL %s exp %0h got %0h", nm, ex, gt); end end

module tb_watchdog_timer;
	localparam logic [31:0] A_CTRL = {`WATCHDOG_CTRL_INDEX, 2'b00};
	localparam logic [31:0] A_CSR  = {`WATCHDOG_CSR_INDEX, 2'b00};
	localparam logic [31:0] A_NONE = 32'h0000_0050;

	logic        ref_clk;
	logic        por;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] rdat;
	logic        hw_rst_opt;
	logic        hw_int_opt;
	logic        halt;
	wire  logic        sys_rst;
	wire  logic        cpu_rst;
	wire  logic        hreadyout;
	wire  logic        hresp;
	wire  logic [31:0] hrdata;
	wire  logic        wdg_reset_req;
	wire  logic        top_level_interrupt;
	int          error_cnt;
	int          n_checks;
	int          rst_cnt;
	int          irq_cnt;
	int          exp_rst;
	int          exp_irq;
	int          waited;
	int          cycles;

	assign sys_rst = por | cpu_rst;

	watchdog_timer #(.TICK_CYCLES(8)) i_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.hardware_reset_option(hw_rst_opt), .hardware_interrupt_option(hw_int_opt),
		.halt_mode(halt),
		.wdg_reset_req(wdg_reset_req), .top_level_interrupt(top_level_interrupt));

	wdg_host_model i_host (
		.ref_clk(ref_clk), .wdg_reset_req(wdg_reset_req),
		.top_level_interrupt(top_level_interrupt), .cpu_rst(cpu_rst),
		.rst_cnt(rst_cnt), .irq_cnt(irq_cnt));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// ---------------------------------------------------------------
	// bus and event tasks
	// ---------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] ex,
		input string nm);
		xfer(1'b0, a, 8'h00);
		`CHK(nm, ex, rdat & m)
	endtask : rd_chk

	// returns at the first new event or after lim cycles
	task automatic wait_ev(input int lim);
		waited = 0;
		while (waited < lim && rst_cnt == exp_rst && irq_cnt == exp_irq) begin
			@(posedge ref_clk);
			waited++;
		end
	endtask : wait_ev

	// a few extra cycles let a stretched pulse count twice
	task automatic ev_chk(input string nm);
		repeat (3) @(posedge ref_clk);
		while (sys_rst !== 1'b0) @(posedge ref_clk);
		@(posedge ref_clk);
		`CHK({nm, " resets"}, exp_rst, rst_cnt)
		`CHK({nm, " interrupts"}, exp_irq, irq_cnt)
	endtask : ev_chk

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		por = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{hw_rst_opt, hw_int_opt, halt} = 3'b000;
		{error_cnt, n_checks, exp_rst, exp_irq, cycles} = '0;
		repeat (6) @(posedge ref_clk);
		por <= 1'b0;
		@(posedge ref_clk);
		rd_chk(A_CTRL, 32'hffff_ffff, 32'h0000_007f, "ctrl reset");
		rd_chk(A_CSR, 32'hffff_ffff, 32'h0000_0000, "csr reset");
		rd_chk(A_NONE, 32'hffff_ffff, 32'h0000_0000, "unmapped");
		`CHK("hresp", 1'b0, hresp)
		$display("test reset values done");
		wr(A_CTRL, 8'h41);
		wait_ev(40);
		ev_chk("unarmed");
		rd_chk(A_CTRL, 32'h0000_00c0, 32'h0000_0000, "free run");
		$display("test unarmed done");
		wr(A_CSR, 8'h01);
		wr(A_CTRL, 8'h41);
		wait_ev(30);
		`CHK("step timing", 1'b1, 1'(waited >= 9 && waited <= 19))
		exp_irq++;
		rd_chk(A_CSR, 32'hffff_ffff, 32'h0000_0003, "flag set");
		rd_chk(A_CSR, 32'hffff_ffff, 32'h0000_0001, "flag cleared");
		wr(A_CSR, 8'h00);
		rd_chk(A_CSR, 32'h0000_00ff, 32'h0000_0001, "enable kept");
		ev_chk("irq once");
		$display("test interrupt mode done");
		halt <= 1'b1;
		wr(A_CTRL, 8'h41);
		wait_ev(60);
		ev_chk("halted");
		rd_chk(A_CTRL, 32'h0000_00ff, 32'h0000_0041, "frozen count");
		halt <= 1'b0;
		wait_ev(30);
		exp_irq++;
		ev_chk("resumed");
		$display("test halt done");
		wr(A_CTRL, 8'hc1);
		wr(A_CTRL, 8'h41);
		rd_chk(A_CTRL, 32'h0000_00c0, 32'h0000_00c0, "activation kept");
		wait_ev(30);
		exp_rst++;
		ev_chk("reset mode");
		rd_chk(A_CTRL, 32'h0000_00ff, 32'h0000_007f, "ctrl after reset");
		rd_chk(A_CSR, 32'h0000_00ff, 32'h0000_0000, "csr after reset");
		$display("test reset mode done");
		wr(A_CTRL, 8'h80);
		wait_ev(8);
		exp_rst++;
		ev_chk("software reset");
		$display("test software reset done");
		hw_rst_opt <= 1'b1;
		hw_int_opt <= 1'b1;
		wr(A_CTRL, 8'h41);
		wait_ev(30);
		exp_rst++;
		ev_chk("both options");
		hw_rst_opt <= 1'b0;
		rd_chk(A_CSR, 32'h0000_00ff, 32'h0000_0001, "forced enable");
		wr(A_CTRL, 8'h41);
		wait_ev(30);
		exp_irq++;
		ev_chk("hw interrupt");
		wr(A_CTRL, 8'hc1);
		wait_ev(30);
		exp_rst++;
		ev_chk("hw interrupt reset");
		$display("test options done");
		tally_and_finish();
	end
endmodule : tb_watchdog_timer
`default_nettype wire
